// ===== bench/test_vc_arbitration_config_regs.sv
`default_nettype none
`include "vcarb_cfg.svh"
module test_vc_arbitration_config_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import vcarb_pkg::*;

   logic          clk;
   logic          reset_n;
   logic          cfg_wr;
   logic          cfg_rd;
   logic [11:0]   cfg_addr;
   logic [3:0]    cfg_be;
   logic [31:0]   cfg_wdata;
   logic [31:0]   cfg_rdata;
   logic          cfg_rd_valid;
   logic          strict_priority_en;
   logic [2:0]    low_prio_ext_count;
   vcarb_scheme_t arb_scheme_choice;
   logic          arb_table_live;
   logic          table_copy_start;
   logic          table_copy_done;
   logic          table_pending_flag;
   logic [31:0]   rd_word;
   int            fails;
   int            checks;

   vcarb_config_regs i_vcarb_config_regs (
      .clk                (clk),
      .reset_n            (reset_n),
      .cfg_wr             (cfg_wr),
      .cfg_rd             (cfg_rd),
      .cfg_addr           (cfg_addr),
      .cfg_be             (cfg_be),
      .cfg_wdata          (cfg_wdata),
      .cfg_rdata          (cfg_rdata),
      .cfg_rd_valid       (cfg_rd_valid),
      .strict_priority_en (strict_priority_en),
      .low_prio_ext_count (low_prio_ext_count),
      .arb_scheme_choice  (arb_scheme_choice),
      .arb_table_live     (arb_table_live),
      .table_copy_start   (table_copy_start),
      .table_copy_done    (table_copy_done),
      .table_pending_flag (table_pending_flag)
   );

   always #2 clk = ~clk;

   // ****************************************
   // Bus and compare helpers
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic cfg_write(input logic [11:0] addr, input logic [3:0] be,
                            input logic [31:0] data);
      @(posedge clk);
      cfg_wr    <= 1'b1;
      cfg_addr  <= addr;
      cfg_be    <= be;
      cfg_wdata <= data;
      @(posedge clk);
      cfg_wr    <= 1'b0;
      #1;
   endtask

   task automatic cfg_read(input logic [11:0] addr);
      @(posedge clk);
      cfg_rd   <= 1'b1;
      cfg_addr <= addr;
      @(posedge clk);
      cfg_rd   <= 1'b0;
      #1;
      check("read valid", {31'h0000_0000, cfg_rd_valid}, 32'h0000_0001);
      rd_word = cfg_rdata;
   endtask

   // Start pulse must already have dropped when done arrives
   task automatic copy_done_pulse;
      @(posedge clk);
      table_copy_done <= 1'b1;
      #1;
      check("copy start", table_copy_start, 32'h0000_0000);
      @(posedge clk);
      table_copy_done <= 1'b0;
      #1;
   endtask

   task automatic print_verdict;
      $display("checks %0d, fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values;
      cfg_read(`VCARB_CAP2_OFF);
      check("capability two", rd_word, 32'h0300_0003);
      cfg_read(`VCARB_CTRL_OFF);
      check("control and status", rd_word, 32'h0000_0000);
      check("scheme choice", arb_scheme_choice, 32'h0000_0000);
      check("ext count", low_prio_ext_count, 32'h0000_0001);
      cfg_write(`VCARB_CAP2_OFF, 4'hf, 32'hffff_ffff);
      cfg_read(`VCARB_CAP2_OFF);
      check("capability two rewritten", rd_word, 32'h0300_0003);
      cfg_read(12'h100);
      check("unmapped read", rd_word, 32'h0000_0000);
   endtask

   task automatic t_scheme_choice;
      // Only the two implemented codes are written
      for (int i = 0; i < 2; i++) begin
         cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_fff0 | (i << 1));
         check("scheme choice", arb_scheme_choice, i);
         cfg_write(`VCARB_CTRL_OFF, 4'he, 32'h0000_0000);
         cfg_read(`VCARB_CTRL_OFF);
         check("control readback", rd_word, i << 1);
      end
      cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_0000);
      check("scheme choice back", arb_scheme_choice, 32'h0000_0000);
   endtask

   task automatic t_pending;
      cfg_write(12'h180, 4'h1, 32'h0000_0005);
      check("pending after table write", table_pending_flag, 32'h0000_0001);
      cfg_read(`VCARB_CTRL_OFF);
      check("status word", rd_word, 32'h0001_0000);
      cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_0001);
      check("copy start", table_copy_start, 32'h0000_0001);
      check("pending during copy", table_pending_flag, 32'h0000_0001);
      copy_done_pulse();
      check("pending after copy", table_pending_flag, 32'h0000_0000);
      cfg_read(`VCARB_CTRL_OFF);
      check("load bit reads zero", rd_word, 32'h0000_0000);
      // A table write landing mid-copy must survive the done
      cfg_write(12'h18c, 4'h8, 32'ha000_0000);
      cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_0001);
      check("second copy start", table_copy_start, 32'h0000_0001);
      cfg_write(12'h184, 4'h2, 32'h0000_3300);
      copy_done_pulse();
      check("late write kept", table_pending_flag, 32'h0000_0001);
      cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_0001);
      copy_done_pulse();
      check("pending cleared", table_pending_flag, 32'h0000_0000);
   endtask

   task automatic t_strict;
      @(posedge clk);
      strict_priority_en <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("strict count", low_prio_ext_count, 32'h0000_0000);
      check("table scratch", arb_table_live, 32'h0000_0000);
      cfg_read(`VCARB_CAP2_OFF);
      check("capability two strict", rd_word, 32'h0000_0000);
      cfg_write(12'h188, 4'hf, 32'h1234_5678);
      @(posedge clk);
      #1;
      check("scratch write", table_pending_flag, 32'h0000_0000);
      cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_0001);
      check("scratch load", table_copy_start, 32'h0000_0000);
      @(posedge clk);
      strict_priority_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check("normal count", low_prio_ext_count, 32'h0000_0001);
      check("table live", arb_table_live, 32'h0000_0001);
   endtask

   task automatic t_reset_again;
      cfg_write(`VCARB_CTRL_OFF, 4'h1, 32'h0000_0002);
      cfg_write(12'h180, 4'h1, 32'h0000_0001);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check("choice after reset", arb_scheme_choice, 32'h0000_0000);
      check("pending after reset", table_pending_flag, 32'h0000_0000);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      clk                = 1'b0;
      reset_n            = 1'b0;
      cfg_wr             = 1'b0;
      cfg_rd             = 1'b0;
      cfg_addr           = 12'h000;
      cfg_be             = 4'h0;
      cfg_wdata          = 32'h0000_0000;
      strict_priority_en = 1'b0;
      table_copy_done    = 1'b0;
      fails              = 0;
      checks             = 0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_reset_values();
      t_scheme_choice();
      t_pending();
      t_strict();
      t_reset_again();
      print_verdict();
   end

   // Whole run needs under a hundred cycles; allow far more
   initial begin
      #40000;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire

// ===== verilog/vcarb_cfg.svh
`ifndef VCARB_CFG_SVH
`define VCARB_CFG_SVH
// What this block does
// - Table location reads 00h when extended count is 000b, else 03h.
// - With location 00h the table is scratch; its writes never reach arbitration.
// - Capability two bits 23:8 always read zero.
// - Support field: bit0 fixed round-robin, bits1-3 weighted 32/64/128, rest reserved.
// - Support field reads 00h when extended count is 000b, else 03h.
// - Scheme choice bits 3:1 are read/write and name the support bit used.
// - Scheme choice resets to 000 fixed round-robin; 001 picks 32-phase weighted.
// - Writing 1 to control bit 0 copies the table while the location is 03h and no copy runs; the bit reads 0.
// - Control bits 15:4 always read zero.
// - Pending flag sets whenever any table entry is written while the location is 03h.
// - Pending flag clears only after a requested copy has finished.
// - Status bits 15:1 read zero; control and status reset to 0000h.
// - Extended count is 001b without strict priority, 000b with it.

// ****************************************
// Register map
// ****************************************
`define VCARB_CAP_BASE        12'h150
`define VCARB_CAP2_OFF        12'h158
`define VCARB_CTRL_OFF        12'h15c
`define VCARB_STATUS_OFF      12'h15e
`define VCARB_TBL_LOC_UNIT    12'h010
`define VCARB_TBL_BYTES       12'h010

// ****************************************
// Fields and values
// ****************************************
`define VCARB_LOC_LSB         24
`define VCARB_STATUS_SHIFT    16
`define VCARB_STROBE_BIT      0
`define VCARB_CHOICE_LSB      1
`define VCARB_CHOICE_MSB      3
`define VCARB_TBL_LOC_LIVE    8'h03
`define VCARB_TBL_LOC_NONE    8'h00
`define VCARB_SUPPORT_LIVE    8'h03
`define VCARB_SUPPORT_NONE    8'h00
`define VCARB_CHOICE_RESET    3'h0
`define VCARB_CHOICE_WRR32    3'h1
`define VCARB_COUNT_NORMAL    3'h1
`define VCARB_COUNT_STRICT    3'h0
`define VCARB_CTRL_RESET      16'h0000
`define VCARB_STATUS_RESET    16'h0000

`endif

// ===== verilog/vcarb_config_regs.sv
`default_nettype none
`include "vcarb_cfg.svh"
module vcarb_config_regs (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic                      cfg_wr,
   input  wire logic                      cfg_rd,
   input  wire logic [11:0]               cfg_addr,
   input  wire logic [3:0]                cfg_be,
   input  wire logic [31:0]               cfg_wdata,
   output logic [31:0]                    cfg_rdata,
   output logic                           cfg_rd_valid,
   input  wire logic                      strict_priority_en,
   output logic [2:0]                     low_prio_ext_count,
   output var vcarb_pkg::vcarb_scheme_t   arb_scheme_choice,
   output logic                           arb_table_live,
   output logic                           table_copy_start,
   input  wire logic                      table_copy_done,
   output logic                           table_pending_flag
);
   import vcarb_pkg::*;

   // ****************************************
   // Address decode
   // ****************************************
   localparam logic [11:0] CAP2_ADDR = `VCARB_CAP2_OFF;
   localparam logic [11:0] CTRL_ADDR = `VCARB_CTRL_OFF;
   localparam logic [11:0] TBL_BASE  = `VCARB_CAP_BASE
                                     + 12'(`VCARB_TBL_LOC_LIVE) * `VCARB_TBL_LOC_UNIT;
   localparam logic [11:0] TBL_END   = TBL_BASE + `VCARB_TBL_BYTES;

   logic          hit_cap2;
   logic          hit_ctrl;
   logic          hit_tbl;
   logic          ctrl_wr;
   logic          strobe_wr;
   vcarb_scheme_t wr_choice;
   logic [2:0]    next_count;
   logic [7:0]    tbl_location;
   logic [7:0]    scheme_support;
   logic [31:0]   cap2_word;
   logic [15:0]   ctrl_half;
   logic [15:0]   status_half;
   logic [31:0]   ctrl_word;
   logic [31:0]   rd_word;

   // Control and status share one dword; status sits in lanes 2 and 3
   assign hit_cap2  = (cfg_addr[11:2] == CAP2_ADDR[11:2]);
   assign hit_ctrl  = (cfg_addr[11:2] == CTRL_ADDR[11:2]);
   assign hit_tbl   = (cfg_addr >= TBL_BASE) && (cfg_addr < TBL_END);
   assign ctrl_wr   = cfg_wr & hit_ctrl & cfg_be[0];
   assign wr_choice = cfg_wdata[`VCARB_CHOICE_MSB:`VCARB_CHOICE_LSB];
   assign strobe_wr = ctrl_wr & cfg_wdata[`VCARB_STROBE_BIT];

   // ****************************************
   // Extended count and table presence
   // ****************************************
   assign next_count = strict_priority_en ? `VCARB_COUNT_STRICT
                                          : `VCARB_COUNT_NORMAL;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         low_prio_ext_count <= `VCARB_COUNT_NORMAL;
         arb_table_live     <= 1'b1;
      end else begin
         low_prio_ext_count <= next_count;
         arb_table_live     <= (next_count != 3'h0);
      end
   end

   // ****************************************
   // Scheme choice
   // ****************************************
   // Reserved codes are stored as written; software must not use them
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arb_scheme_choice <= `VCARB_CHOICE_RESET;
      end else if (ctrl_wr) begin
         arb_scheme_choice <= wr_choice;
      end
   end

   // ****************************************
   // Table load and pending tracking
   // ****************************************
   vcarb_seq_if seq_bus ();

   // Scratch table: writes and loads never reach the arbiter
   assign seq_bus.load_req  = strobe_wr & arb_table_live;
   assign seq_bus.table_mod = cfg_wr & hit_tbl & (|cfg_be)
                            & arb_table_live;
   assign seq_bus.copy_done = table_copy_done;
   assign table_copy_start  = seq_bus.copy_start;
   assign table_pending_flag = seq_bus.pending;

   vcarb_load_seq u_load_seq (
      .clk     (clk),
      .reset_n (reset_n),
      .bus     (seq_bus.seq)
   );

   // ****************************************
   // Read path
   // ****************************************
   assign tbl_location   = arb_table_live ? `VCARB_TBL_LOC_LIVE
                                          : `VCARB_TBL_LOC_NONE;
   assign scheme_support = arb_table_live ? `VCARB_SUPPORT_LIVE
                                          : `VCARB_SUPPORT_NONE;
   assign cap2_word      = {tbl_location, 16'h0000, scheme_support};
   // Load strobe is never stored, so it always reads back as 0
   assign ctrl_half      = {12'h000, arb_scheme_choice, 1'b0};
   assign status_half    = {15'h0000, table_pending_flag};
   assign ctrl_word      = {status_half, ctrl_half};
   // Table storage lives elsewhere; unclaimed addresses read zero
   assign rd_word        = hit_cap2 ? cap2_word
                         : hit_ctrl ? ctrl_word
                         : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_rdata    <= 32'h0000_0000;
         cfg_rd_valid <= 1'b0;
      end else begin
         cfg_rd_valid <= cfg_rd;
         if (cfg_rd) begin
            cfg_rdata <= rd_word;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_rd_cap2;
      cfg_rd && hit_cap2;
   endsequence
   sequence s_rd_ctrl;
      cfg_rd && hit_ctrl;
   endsequence

   property p_loc;
      s_rd_cap2 |=> cfg_rd_valid
         && cfg_rdata[31:`VCARB_LOC_LSB] == (($past(low_prio_ext_count) == 3'h0)
            ? `VCARB_TBL_LOC_NONE : `VCARB_TBL_LOC_LIVE);
   endproperty
   property p_support;
      s_rd_cap2 |=> cfg_rdata[7:4] == 4'h0
         && cfg_rdata[7:0] == (($past(low_prio_ext_count) == 3'h0)
            ? `VCARB_SUPPORT_NONE : `VCARB_SUPPORT_LIVE);
   endproperty
   property p_status;
      s_rd_ctrl |=> cfg_rdata[31:17] == 15'h0000
         && cfg_rdata[`VCARB_STATUS_SHIFT] == $past(table_pending_flag);
   endproperty

   AST_TBL_LOC: assert property (p_loc)
      else $error("table location field wrong");
   AST_SCRATCH: assert property (!arb_table_live && !table_pending_flag
                                 |=> !table_pending_flag)
      else $error("scratch table write set pending flag");
   AST_CAP2_RSVD: assert property (s_rd_cap2 |=> cfg_rdata[23:8] == 16'h0000)
      else $error("capability two reserved bits nonzero");
   AST_SUPPORT: assert property (p_support)
      else $error("scheme support field wrong");
   AST_CHOICE: assert property (ctrl_wr |=> arb_scheme_choice == $past(wr_choice))
      else $error("scheme choice not written");
   AST_RESET_VAL: assert property (@(posedge clk) disable iff (1'b0)
                                   !reset_n |=> arb_scheme_choice == `VCARB_CHOICE_RESET
                                   && !table_pending_flag)
      else $error("control or status not reset");
   AST_CTRL_RSVD: assert property (s_rd_ctrl |=> cfg_rdata[15:4] == 12'h000
                                   && !cfg_rdata[`VCARB_STROBE_BIT])
      else $error("control reserved or strobe bit nonzero");
   AST_STATUS: assert property (p_status)
      else $error("status read wrong");
   AST_STRICT: assert property (strict_priority_en |=> low_prio_ext_count ==
                                `VCARB_COUNT_STRICT && !arb_table_live)
      else $error("strict priority count wrong");

   // ****************************************
   // Output-level checks
   // ****************************************
   // These watch the top outputs, so a broken sequencer hookup shows up here
   sequence s_scratch_load;
      strobe_wr && !arb_table_live;
   endsequence
   sequence s_tbl_write;
      cfg_wr && hit_tbl && (|cfg_be) && arb_table_live;
   endsequence

   property p_normal;
      !strict_priority_en |=> low_prio_ext_count == `VCARB_COUNT_NORMAL
         && arb_table_live;
   endproperty
   property p_choice_rd;
      s_rd_ctrl |=> cfg_rdata[`VCARB_CHOICE_MSB:`VCARB_CHOICE_LSB]
         == $past(arb_scheme_choice);
   endproperty
   property p_pend_hold;
      table_pending_flag && !table_copy_done |=> table_pending_flag;
   endproperty

   AST_NORMAL: assert property (p_normal)
      else $error("normal priority count wrong");
   AST_SCRATCH_LOAD: assert property (s_scratch_load |=> !table_copy_start)
      else $error("scratch table load started a copy");
   AST_NO_STRAY_START: assert property (!strobe_wr |=> !table_copy_start)
      else $error("copy started without a load write");
   AST_CHOICE_HOLD: assert property (!ctrl_wr |=> $stable(arb_scheme_choice))
      else $error("scheme choice changed without a write");
   AST_CHOICE_RD: assert property (p_choice_rd)
      else $error("scheme choice read back wrong");
   AST_SUPPORT_RSVD: assert property (s_rd_cap2 |=> cfg_rdata[7:4] == 4'h0)
      else $error("reserved support bits nonzero");
   AST_TBL_WRITE: assert property (s_tbl_write |=> table_pending_flag)
      else $error("table write did not flag pending");
   AST_PEND_HOLD: assert property (p_pend_hold)
      else $error("pending flag dropped without copy done");
endmodule
`default_nettype wire

// ===== verilog/vcarb_load_seq.sv
`default_nettype none
module vcarb_load_seq (
   input  wire logic clk,
   input  wire logic reset_n,
   vcarb_seq_if.seq  bus
);
   import vcarb_pkg::*;

   vcarb_state_t state;
   vcarb_state_t next_state;
   logic         mod_seen;
   logic         next_mod_seen;
   logic         next_pending;
   logic         st_idle;
   logic         st_copy;
   logic         start_now;
   logic         done_accept;

   // ****************************************
   // Copy sequencing
   // ****************************************
   assign st_idle     = (state == VCARB_IDLE);
   assign st_copy     = (state == VCARB_COPY);
   // A request during a copy is dropped; the pending flag still tells software
   assign start_now   = st_idle & bus.load_req;
   assign done_accept = st_copy & bus.copy_done;

   always_comb begin
      next_state = state;
      case (state)
         VCARB_IDLE: begin
            if (bus.load_req) begin
               next_state = VCARB_COPY;
            end
         end
         VCARB_COPY: begin
            if (bus.copy_done) begin
               next_state = VCARB_IDLE;
            end
         end
         default: begin
            next_state = VCARB_IDLE;
         end
      endcase
   end

   // ****************************************
   // Pending flag
   // ****************************************
   // A write in the start cycle may miss the copy, so it counts as late
   always_comb begin
      next_mod_seen = mod_seen;
      if (start_now) begin
         next_mod_seen = bus.table_mod;
      end else if (done_accept) begin
         next_mod_seen = 1'b0;
      end else if (st_copy && bus.table_mod) begin
         next_mod_seen = 1'b1;
      end
   end

   // Set wins over the clear of a finishing copy
   assign next_pending = bus.table_mod
                       | (bus.pending & ~(done_accept & ~mod_seen));

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state          <= VCARB_IDLE;
         mod_seen       <= 1'b0;
         bus.pending    <= 1'b0;
         bus.copy_start <= 1'b0;
      end else begin
         state          <= next_state;
         mod_seen       <= next_mod_seen;
         bus.pending    <= next_pending;
         bus.copy_start <= start_now;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_start;
      st_idle && bus.load_req;
   endsequence
   sequence s_copy_pulse;
      bus.copy_start ##1 !bus.copy_start;
   endsequence
   sequence s_late_mod;
      st_copy && bus.table_mod;
   endsequence

   property p_start;
      s_start |=> s_copy_pulse;
   endproperty
   property p_keep;
      s_late_mod ##[1:2] done_accept |=> bus.pending;
   endproperty

   AST_LOAD_START: assert property (p_start)
      else $error("table copy start pulse missing");
   AST_NO_RESTART: assert property (st_copy |=> !bus.copy_start)
      else $error("copy restarted while busy");
   AST_PEND_SET: assert property (bus.table_mod |=> bus.pending)
      else $error("pending flag not set by table write");
   AST_PEND_CLEAR: assert property ($fell(bus.pending) |-> $past(done_accept))
      else $error("pending flag cleared without finished copy");
   AST_PEND_KEEP: assert property (p_keep)
      else $error("late table write lost at copy end");
endmodule
`default_nettype wire

// ===== verilog/vcarb_pkg.sv
`default_nettype none
package vcarb_pkg;
   typedef logic [2:0] vcarb_scheme_t;
   typedef enum logic [1:0] {
      VCARB_IDLE = 2'b01,
      VCARB_COPY = 2'b10
   } vcarb_state_t;
endpackage
`default_nettype wire

// ===== verilog/vcarb_seq_if.sv
`default_nettype none
interface vcarb_seq_if;
   logic load_req;
   logic table_mod;
   logic copy_done;
   logic copy_start;
   logic pending;
   modport ctrl (
      output load_req,
      output table_mod,
      output copy_done,
      input  copy_start,
      input  pending
   );
   modport seq (
      input  load_req,
      input  table_mod,
      input  copy_done,
      output copy_start,
      output pending
   );
endinterface
`default_nettype wire
